// ==== rtl/tmr16.sv ====
// Sixteen-bit timer/counter with three-bit prescaler and control register.
// Assumes all pin inputs are already synchronous to clock_i and that the
// register master follows the one-cycle strobe protocol.
`timescale 1ns/1ns
module tmr16
	import tmr16_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire tmr16_pkg::reg_req_t req_i,
	output logic [7:0] rdata_o,
	input wire logic sleep_i,
	input wire logic special_event_i,
	input wire logic osc_input_pin_i,
	input wire logic ext_clock_pin_i,
	output logic osc_output_pin_o,
	output logic osc_power_o,
	output logic overflow_irq_o,
	output logic wake_o,
	output logic time_base_valid_o,
	output logic [15:0] time_base_o
);
	import tmr16_pkg::*;

	timer_control_t ctrl_q;
	logic flag_q, irq_en_q, src_prev_q, armed_q, presc_prev_q;
	logic sync1_q, sync2_q, sync_prev_q, wake_q, loaded_q;
	logic [15:0] count_q;
	logic [15:0] time_base_q;
	logic [2:0] presc_q;
	logic [1:0] instr_div_q;
	logic [7:0] rdata_q;
	count_mode_t mode;
	logic src_level, src_fall, src_rise, instr_tick, presc_in;
	logic presc_level, presc_carry, inc, wr_lo, wr_hi, cnt_wr, overflow;

	// Selects the level of a prescaler stage for the chosen ratio
	function automatic logic stage_level(input logic [1:0] sel,
		input logic src, input logic [2:0] cnt);
		case (sel)
			PS_DIV2: return cnt[0];
			PS_DIV4: return cnt[1];
			PS_DIV8: return cnt[2];
			default: return src;
		endcase
	endfunction

	// Is the prescaler about to produce a carry at this ratio
	function automatic logic stage_carry(input logic [1:0] sel,
		input logic [2:0] cnt);
		case (sel)
			PS_DIV2: return cnt[0];
			PS_DIV4: return &cnt[1:0];
			PS_DIV8: return &cnt;
			default: return 1'b1;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// Mode decode and source selection

	// Source select low forces timer mode whatever sync-disable says
	assign mode = !ctrl_q.clock_source_select ? MODE_TIMER
		: (ctrl_q.sync_disable_n ? MODE_ASYNC_CNT : MODE_SYNC_CNT);

	// Oscillator pin when the oscillator runs, otherwise the clock pin
	assign src_level = ctrl_q.osc_enable ? osc_input_pin_i
		: ext_clock_pin_i;
	assign src_fall = src_prev_q && !src_level;
	assign src_rise = !src_prev_q && src_level;

	// Inverting amplifier output; gated off to draw no power
	assign osc_power_o = ctrl_q.osc_enable;
	assign osc_output_pin_o = ctrl_q.osc_enable && !osc_input_pin_i;

	assign wr_lo = req_i.wr && (req_i.addr == CNT_LO_ADDR);
	assign wr_hi = req_i.wr && (req_i.addr == CNT_HI_ADDR);
	assign cnt_wr = wr_lo || wr_hi;

	////////////////////////////////////////////////////////////////////
	// Instruction clock enable: core oscillator divided by four

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			instr_div_q <= 2'h0;
		else if (instr_div_q == INSTR_LAST)
			instr_div_q <= 2'h0;
		else
			instr_div_q <= instr_div_q + 2'h1;
	end
	assign instr_tick = (instr_div_q == INSTR_LAST);

	////////////////////////////////////////////////////////////////////
	// External edge tracking and falling-edge arm

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			src_prev_q <= 1'b0;
		else
			src_prev_q <= src_level;
	end

	// Disarmed whenever stopped or in timer mode, so that a high pin at
	// enable time cannot count as a rising edge
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			armed_q <= 1'b0;
		else if (!ctrl_q.timer_on || mode == MODE_TIMER)
			armed_q <= 1'b0;
		else if (src_fall)
			armed_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// Prescaler: counts instruction ticks or armed external rises

	assign presc_in = ctrl_q.timer_on && ((mode == MODE_TIMER) ? instr_tick
		: (armed_q && src_rise));

	// Keeps running in sleep, since it lives on the external edges
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			presc_q <= 3'h0;
		else if (cnt_wr)
			presc_q <= 3'h0;
		else if (presc_in)
			presc_q <= presc_q + 3'h1;
	end

	assign presc_carry = presc_in
		&& stage_carry(ctrl_q.prescale_select, presc_q);
	assign presc_level = stage_level(ctrl_q.prescale_select,
		src_level && armed_q, presc_q);

	////////////////////////////////////////////////////////////////////
	// Synchroniser and unsynchronised edge path

	// Two stages after the prescaler; held in sleep as the
	// synchroniser is powered down there
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync_prev_q <= 1'b0;
		end
		else if (!sleep_i)
		begin
			sync1_q <= presc_level;
			sync2_q <= sync1_q;
			sync_prev_q <= sync2_q;
		end
	end

	// Unsynchronised path sees the prescaler output two stages earlier
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			presc_prev_q <= 1'b0;
		else
			presc_prev_q <= presc_level;
	end

	// Increment selection per mode
	always_comb
	begin
		inc = 1'b0;
		case (mode)
			MODE_TIMER: inc = presc_carry;
			MODE_SYNC_CNT: inc = ctrl_q.timer_on && !sleep_i
				&& sync2_q && !sync_prev_q;
			MODE_ASYNC_CNT: inc = ctrl_q.timer_on
				&& presc_level && !presc_prev_q;
			default: inc = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Sixteen-bit count; deliberately not reset

	assign overflow = inc && (count_q == 16'hFFFF);

	// A byte write wins over a special event clear and over counting
	always_ff @(posedge clock_i)
	begin
		if (wr_lo)
			count_q <= {count_q[15:8], req_i.wdata};
		else if (wr_hi)
			count_q <= {req_i.wdata, count_q[7:0]};
		else if (special_event_i && mode != MODE_ASYNC_CNT)
			count_q <= 16'h0000;
		else if (inc)
			count_q <= count_q + 16'h0001;
	end

	// Count has no reset; checks on its value wait for a first write
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			loaded_q <= 1'b0;
		else if (cnt_wr)
			loaded_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// Control, flag and enable registers

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ctrl_q <= timer_control_t'(CTRL_RESET);
		else if (req_i.wr && req_i.addr == CTRL_ADDR)
			ctrl_q <= timer_control_t'(req_i.wdata & CTRL_WMASK);
	end

	// Overflow sets win over a software clear in the same cycle
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			flag_q <= FLAG_RESET[0];
		else if (overflow)
			flag_q <= 1'b1;
		else if (req_i.wr && req_i.addr == FLAG_ADDR)
			flag_q <= req_i.wdata[0];
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_en_q <= 1'b0;
		else if (req_i.wr && req_i.addr == IRQ_EN_ADDR)
			irq_en_q <= req_i.wdata[0];
	end

	assign overflow_irq_o = flag_q && irq_en_q;

	// Wake pulse only for an asynchronous overflow while asleep
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			wake_q <= 1'b0;
		else
			wake_q <= overflow && irq_en_q && sleep_i
				&& mode == MODE_ASYNC_CNT;
	end
	assign wake_o = wake_q;

	////////////////////////////////////////////////////////////////////
	// Read port and capture/compare time base

	// Count is held in core-clock flops, so every byte read is clean
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_q <= 8'h00;
		else if (!req_i.rd)
			rdata_q <= 8'h00;
		else
		begin
			case (req_i.addr)
				CTRL_ADDR: rdata_q <= ctrl_q & CTRL_WMASK;
				FLAG_ADDR: rdata_q <= {7'h00, flag_q};
				IRQ_EN_ADDR: rdata_q <= {7'h00, irq_en_q};
				CNT_LO_ADDR: rdata_q <= count_q[7:0];
				CNT_HI_ADDR: rdata_q <= count_q[15:8];
				default: rdata_q <= 8'h00;
			endcase
		end
	end
	assign rdata_o = rdata_q;

	// Withheld in asynchronous mode
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			time_base_q <= 16'h0000;
		else if (mode == MODE_ASYNC_CNT)
			time_base_q <= 16'h0000;
		else
			time_base_q <= count_q;
	end
	assign time_base_o = time_base_q;
	assign time_base_valid_o = (mode != MODE_ASYNC_CNT);

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking assert_cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	a_ctrl_top_zero: assert property (ctrl_q[7:6] == 2'h0)
		else $error("control top bits not zero");

	// The count is unknown until written, so the hold check waits
	a_stop_holds: assert property (
		(loaded_q && !ctrl_q.timer_on && !req_i.wr && !special_event_i)
		|=> count_q == $past(count_q))
		else $error("count moved while stopped");

	a_wrap_flag: assert property (
		(inc && count_q == 16'hFFFF && !cnt_wr) |=> count_q == 16'h0000
		&& flag_q)
		else $error("wrap did not set flag");

	a_presc_clear: assert property (cnt_wr |=> presc_q == 3'h0)
		else $error("prescaler not cleared on count write");

	a_arm_first: assert property (
		(mode != MODE_TIMER && !armed_q) |-> !inc)
		else $error("count before falling edge");

	a_sync_sleep: assert property (
		(mode == MODE_SYNC_CNT && sleep_i && !req_i.wr
		&& !special_event_i) |=> count_q == $past(count_q))
		else $error("synchronised count moved in sleep");

	a_timer_rate: assert property (
		(mode == MODE_TIMER && inc) |-> instr_tick)
		else $error("timer increment off instruction tick");

	a_div_eight: assert property (
		(mode == MODE_TIMER && ctrl_q.prescale_select == PS_DIV8 && inc)
		|-> presc_q == 3'h7)
		else $error("1:8 carry at wrong count");

	a_no_time_base: assert property (
		mode == MODE_ASYNC_CNT |=> $past(mode) != MODE_ASYNC_CNT
		|| time_base_o == 16'h0000)
		else $error("time base offered in asynchronous mode");

	// Four awake cycles cover both sync stages and the edge history
	a_sync_delay: assert property (
		(!sleep_i [*4] ##0 mode == MODE_SYNC_CNT && inc)
		|-> $past(presc_level, 2) && !$past(presc_level, 3))
		else $error("synchronised increment not two stages late");

	c_async_wrap: cover property (mode == MODE_ASYNC_CNT && overflow);
	c_sync_inc: cover property (mode == MODE_SYNC_CNT && inc);
	c_sleep_wake: cover property (wake_o);
	c_timer_div8: cover property (mode == MODE_TIMER
		&& ctrl_q.prescale_select == PS_DIV8 && inc);

endmodule

// ==== inc/tmr16_pkg.sv ====
// Package for the sixteen-bit timer/counter: register map, control
// field layout, reset values, modes and bus carrier types.
// Assumes a single 250 MHz core clock; the instruction clock is core/4.
package tmr16_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] CTRL_ADDR = 8'h10;
	localparam logic [7:0] FLAG_ADDR = 8'h0C;
	localparam logic [7:0] IRQ_EN_ADDR = 8'h0D;
	localparam logic [7:0] CNT_LO_ADDR = 8'h0E;
	localparam logic [7:0] CNT_HI_ADDR = 8'h0F;

	// Control field positions
	localparam int ON_BIT = 0;
	localparam int CS_BIT = 1;
	localparam int SYNC_N_BIT = 2;
	localparam int OSC_EN_BIT = 3;
	localparam int PS_LSB = 4;

	// Reset values and writable mask (bits 7-6 unimplemented)
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h3F;
	localparam logic [7:0] FLAG_RESET = 8'h00;

	// Timing: instruction clock is the core oscillator divided by four
	localparam int CLK_PERIOD_NS = 4;
	localparam int INSTR_DIV = 4;
	localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

	// Prescale select encodings
	localparam logic [1:0] PS_DIV1 = 2'h0;
	localparam logic [1:0] PS_DIV2 = 2'h1;
	localparam logic [1:0] PS_DIV4 = 2'h2;
	localparam logic [1:0] PS_DIV8 = 2'h3;

	typedef struct packed {
		logic [1:0] unused;
		logic [1:0] prescale_select;
		logic osc_enable;
		logic sync_disable_n;
		logic clock_source_select;
		logic timer_on;
	} timer_control_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef enum logic [1:0] {
		MODE_TIMER,
		MODE_SYNC_CNT,
		MODE_ASYNC_CNT
	} count_mode_t;

endpackage

// ==== testbench/clock_source_model.sv ====
// Model of the far-side clock source: a crystal on the oscillator pins or
// a plain clock on the external clock pin. Assumes the bench calls pulses
// right after a rising edge of clock_i.
`timescale 1ns/1ns
module clock_source_model
(
	input wire logic clock_i,
	input wire logic sel_osc_i,
	output logic osc_input_pin_o,
	output logic ext_clock_pin_o
);
	logic main_q = 1'b0;
	logic alt_q = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// The unselected pin toggles at twice the rate, so counting the wrong
	// pin gives a different count instead of passing silently
	assign osc_input_pin_o = sel_osc_i ? main_q : alt_q;
	assign ext_clock_pin_o = sel_osc_i ? alt_q : main_q;

	// n full periods, low start: rise first, then fall; stands still after
	task automatic pulses(input int n);
		repeat (2 * n)
		begin
			repeat (3) @(posedge clock_i);
			alt_q <= ~alt_q;
			repeat (3) @(posedge clock_i);
			main_q <= ~main_q;
			alt_q <= ~alt_q;
		end
	endtask
endmodule

// ==== testbench/sixteen_bit_timer_counter_tb.sv ====
// Self-checking bench for the timer/counter: register port, prescaler,
// overflow, counter modes, sleep. Assumes the package register map.
`timescale 1ns/1ns
module sixteen_bit_timer_counter_tb;
	import tmr16_pkg::*;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	reg_req_t req = '0;
	logic sleep = 1'b0;
	logic sel_osc = 1'b0;
	logic wake_seen = 1'b0;
	logic osc_in, ext_clk, osc_out, osc_pwr, irq, wake, tb_valid;
	logic [7:0] rdata;
	logic [7:0] rv;
	logic [15:0] tbase;
	logic [15:0] cnt;
	int error_cnt = 0;
	int checks = 0;
	int model;
	int div;

	////////////////////////////////////////////////////////////////////////
	// Clock, wake pulse catcher and the two instances
	always #2 clock_i = ~clock_i;
	always @(posedge clock_i) if (wake === 1'b1) wake_seen <= 1'b1;

	tmr16 dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req),
		.rdata_o(rdata), .sleep_i(sleep), .special_event_i(1'b0),
		.osc_input_pin_i(osc_in), .ext_clock_pin_i(ext_clk),
		.osc_output_pin_o(osc_out), .osc_power_o(osc_pwr),
		.overflow_irq_o(irq), .wake_o(wake),
		.time_base_valid_o(tb_valid), .time_base_o(tbase));
	clock_source_model src_u (.clock_i(clock_i), .sel_osc_i(sel_osc),
		.osc_input_pin_o(osc_in), .ext_clock_pin_o(ext_clk));

	////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and bus tasks
	task check(input string what, input logic [15:0] got,
		input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task tally_and_finish;
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One-cycle strobes with an idle cycle after, so no signal is driven
	// twice in one time step when tasks follow each other
	task wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock_i);
		req <= '0;
		@(posedge clock_i);
	endtask

	task rd(input logic [7:0] a, output logic [7:0] d);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock_i);
		req <= '0;
		#1 d = rdata;
		@(posedge clock_i);
	endtask

	// High, low, high; low byte read again when a carry slipped between
	task read_count(output logic [15:0] v);
		logic [7:0] h1, lo, h2;
		rd(CNT_HI_ADDR, h1);
		rd(CNT_LO_ADDR, lo);
		rd(CNT_HI_ADDR, h2);
		if (h1 !== h2) rd(CNT_LO_ADDR, lo);
		v = {h2, lo};
	endtask

	// Callers stop the timer first; low cleared before the high write
	task load(input logic [15:0] v);
		wr(CNT_LO_ADDR, 8'h00);
		wr(CNT_HI_ADDR, v[15:8]);
		wr(CNT_LO_ADDR, v[7:0]);
	endtask

	// Counter-mode run: enable, n source periods, stop, read the count
	task ext_run(input logic [7:0] c, input int n, output logic [15:0] v);
		wr(CTRL_ADDR, c);
		src_u.pulses(n);
		wr(CTRL_ADDR, c & 8'hFE);
		read_count(v);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clock_i);
		error_cnt++;
		tally_and_finish;
	end

	// Main sequence
	initial
	begin
		void'($urandom(32'h742fd432));
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		rd(CTRL_ADDR, rv);
		check("ctrl reset", {8'h00, rv}, {8'h00, CTRL_RESET});
		wr(CTRL_ADDR, 8'hFF);
		wr(CTRL_ADDR, 8'hFE);
		rd(CTRL_ADDR, rv);
		check("ctrl high bits", {8'h00, rv}, 16'h003E);
		check("osc power on", {15'h0, osc_pwr}, 16'h0001);
		check("osc out on", {15'h0, osc_out}, 16'h0001);
		wr(CTRL_ADDR, 8'h00);
		check("osc power off", {15'h0, osc_pwr}, 16'h0000);
		check("osc out off", {15'h0, osc_out}, 16'h0000);
		rd(8'h20, rv);
		check("unmapped read", {8'h00, rv}, 16'h0000);
		// Every prescale code: window of 3 output periods plus 2 cycles;
		// at 1:1 the divider phase may add one more tick
		for (int ps = 0; ps < 4; ps++)
		begin
			div = 1 << ps;
			model = $urandom_range(0, 65535);
			load(16'(model));
			wr(CTRL_ADDR, 8'(ps << 4) | 8'h01);
			repeat (12 * div) @(posedge clock_i);
			check("time base valid", {15'h0, tb_valid}, 16'h0001);
			wr(CTRL_ADDR, 8'(ps << 4));
			read_count(cnt);
			model = (model + 3) % 65536;
			if (div == 1 && cnt === 16'(model + 1)) model++;
			check("timer count", cnt, 16'(model));
			check("time base", tbase, 16'(model));
		end
		repeat (20) @(posedge clock_i);
		read_count(cnt);
		check("count held", cnt, 16'(model));
		// Wrap from FFF8 with interrupt enabled
		wr(IRQ_EN_ADDR, 8'h01);
		wr(FLAG_ADDR, 8'h00);
		load(16'hFFF8);
		rd(FLAG_ADDR, rv);
		check("flag before wrap", {8'h00, rv}, 16'h0000);
		wr(CTRL_ADDR, 8'h01);
		repeat (40) @(posedge clock_i);
		wr(CTRL_ADDR, 8'h00);
		rd(FLAG_ADDR, rv);
		check("flag after wrap", {8'h00, rv}, 16'h0001);
		check("irq level", {15'h0, irq}, 16'h0001);
		wr(FLAG_ADDR, 8'h00);
		check("irq cleared", {15'h0, irq}, 16'h0000);
		// Pin starts low: first rise after enable has no prior fall
		load(16'h0000);
		ext_run(8'h03, 5, cnt);
		check("sync ext pin", cnt, 16'h0004);
		sel_osc <= 1'b1;
		load(16'h0000);
		check("osc out follows", {15'h0, osc_out}, 16'h0000);
		ext_run(8'h0B, 5, cnt);
		check("sync osc pin", cnt, 16'h0004);
		// Synchronised mode asleep freezes; asynchronous mode keeps going
		sleep <= 1'b1;
		load(16'h0000);
		ext_run(8'h0B, 5, cnt);
		check("sleep sync", cnt, 16'h0000);
		load(16'hFFFE);
		wake_seen <= 1'b0;
		wr(CTRL_ADDR, 8'h0F);
		check("async time base", {15'h0, tb_valid}, 16'h0000);
		src_u.pulses(5);
		wr(CTRL_ADDR, 8'h0E);
		read_count(cnt);
		check("async count", cnt, 16'h0002);
		check("wake seen", {15'h0, wake_seen}, 16'h0001);
		sleep <= 1'b0;
		tally_and_finish;
	end
endmodule
